// >>> verif/sctlo_cnt_bank.sv
`timescale 1ns/10ps
`default_nettype none
// Stand-in for the counter bank behind the transfer request port
module sctlo_cnt_bank
    import sctlo_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        slow,
    input  wire logic        cnt_req,
    input  wire sctlo_op_t   cnt_op,
    input  wire logic        cnt_dir,
    input  wire logic        cnt_ien,
    input  wire logic [15:0] cnt_sel,
    input  wire logic [31:0] cnt_wdata,
    output logic             cnt_ack,
    output logic [31:0]      cnt_rdata
);
    logic [31:0] cnt [4] = '{default: 32'h0};
    logic [3:0]  ien     = 4'h0;
    logic [2:0]  dly     = 3'h0;
    initial cnt_ack = 1'b0;
    initial cnt_rdata = 32'h0;
    // One ack per request; only four counters, upper select bits alias
    always @(posedge pclk) begin
        cnt_ack <= 1'b0;
        cnt_rdata <= ~cnt_rdata; // Stale data must never look valid
        if (cnt_req && !cnt_ack) begin
            if (dly != 3'h0) begin
                dly <= dly - 3'h1;
            end else begin
                cnt_ack <= 1'b1;
                dly <= slow ? 3'h5 : 3'h0;
                case (cnt_op)
                    OP_INIT: cnt <= '{default: 32'h0};
                    OP_VALUE: begin
                        if (cnt_dir) cnt_rdata <= cnt[cnt_sel[1:0]];
                        else cnt[cnt_sel[1:0]] <= cnt_wdata;
                    end
                    OP_IEN: begin
                        if (cnt_dir) cnt_rdata <= {31'h0, ien[cnt_sel[1:0]]};
                        else ien[cnt_sel[1:0]] <= cnt_ien;
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/sctlo_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sctlo_top_tb;
    import sctlo_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pin = 0;
    logic rx_ok = 1, tx_ok = 1, slow = 0, tgl = 0, err;
    logic [15:0] paddr = 0;
    logic [31:0] pwdata = 0, rnd = 32'ha0c2c2bb, rd, d;
    logic [NUM_LINKS-1:0][STAT_W-1:0] ovf_ev = '0, ev_on_wr = '0;
    logic [31:0] prdata, cnt_wdata, cnt_rdata;
    logic [15:0] cnt_sel;
    logic        pready, pslverr, snap, cnt_req, cnt_dir, cnt_ien, cnt_ack, irq;
    sctlo_op_t   cnt_op;
    logic [3:0]  l;
    logic [12:0] ev, c;
    int          errors = 0, n_checks = 0, snaps = 0, s0;
    logic [15:0] mcmd [9] = '{16'h0303, 16'h0703, 16'h0703, 16'h0303, 16'h0703,
                              16'h0103, 16'h0003, 16'h0203, 16'h0203};
    int          npul [9] = '{0, 0, 0, 0, 0, 5, 3, 7999, 1};
    int          ninc [9] = '{0, 1, 0, 0, 1, 5, 0, 0, 1};

    sctlo_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .counter_snapshot_strobe_pin(pin), .receive_line_clock_alive(rx_ok),
        .transmit_line_clock_alive(tx_ok), .link_ovf_event(ovf_ev), .counter_snapshot(snap),
        .cnt_req, .cnt_op, .cnt_dir, .cnt_ien, .cnt_sel, .cnt_wdata, .cnt_ack, .cnt_rdata, .irq);
    sctlo_cnt_bank bank (.pclk, .slow, .cnt_req, .cnt_op, .cnt_dir, .cnt_ien, .cnt_sel,
        .cnt_wdata, .cnt_ack, .cnt_rdata);

    always #2 pclk = ~pclk;
    // Snapshot pulses last one cycle, so count them on every edge
    always @(posedge pclk) if (snap === 1'b1) snaps <= snaps + 1;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h80200003 : 32'h0);
    endfunction
    // Command readback once idle: done set, toggle as tracked, stored fields
    function automatic logic [31:0] cmd_exp(input logic [15:0] w, input logic t);
        return {20'h0, w[11:8], 1'b1, t, w[5:0]};
    endfunction
    function automatic logic [31:0] stat_exp(input logic [12:0] o, k, e);
        return {19'h0, (o & k) | e};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; events queued in ev_on_wr land in the write's access cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, a, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        if (w) ovf_ev <= ev_on_wr;
        // Only the watchdog ends a wait for the slave's answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        ovf_ev <= '0;
        if (w) tgl = ~tgl;
    endtask
    task automatic xfer(input logic [15:0] cw);
        apb(1, CMD_IDX, {16'h0, cw});
        apb(0, CMD_IDX, 0);
        chk("pending flag", 32'h0, {31'h0, rd[7]});
        for (int i = 0; i < 30 && rd[7] !== 1'b1; i++) apb(0, CMD_IDX, 0);
        chk("command readback", cmd_exp(cw, tgl), rd);
    endtask
    task automatic strobe(input int n);
        repeat (n) begin
            @(posedge pclk);
            pin <= 1'b1;
            repeat (2) @(posedge pclk);
            pin <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic print_verdict;
        if (errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog sized well above the long divided-strobe run
    initial begin
        repeat (90000) @(posedge pclk);
        errors++;
        print_verdict;
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, CMD_IDX, 0);
        chk("command reset", 32'h80, rd);
        apb(0, STAT_IDX, 0);
        chk("status reset", 32'h0, rd);
        apb(0, 12'h400, 0);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(1, 12'h400, 32'hffffffff);
        apb(0, CMD_IDX, 0);
        chk("toggle on any write", cmd_exp(16'h0, tgl), rd);
        // Counter value and enable bit round trips, prompt and slow bank
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            d = lfsr(rnd);
            slow <= rnd[8];
            apb(1, CNT_SEL_IDX, {30'h0, rnd[1:0]});
            apb(1, CNT_HI_IDX, {24'h0, d[31:24]});
            apb(1, CNT_MID_IDX, {16'h0, d[23:8]});
            apb(1, CNT_LO_IDX, {24'h0, d[7:0]});
            xfer(16'h0001);
            xfer(16'h0005);
            apb(0, CNT_HI_IDX, 0);
            chk("upper byte", {24'h0, d[31:24]}, rd);
            apb(0, CNT_MID_IDX, 0);
            chk("middle bytes", {16'h0, d[23:8]}, rd);
            apb(0, CNT_LO_IDX, 0);
            chk("low byte", {24'h0, d[7:0]}, rd);
            xfer({12'h0, rnd[9], 3'b010});
            xfer(16'h0006);
            apb(0, CNT_LO_IDX, 0);
            chk("enable bit", {31'h0, rnd[9]}, rd);
        end
        xfer(16'h0000);
        xfer(16'h0005);
        apb(0, CNT_HI_IDX, 0);
        chk("cleared counter", 32'h0, rd);
        apb(1, CMD_IDX, 32'h3);
        apb(0, CMD_IDX, 0);
        chk("unused op idle", cmd_exp(16'h0003, tgl), rd);
        // Transfer-done interrupt: raise, mask, unmask, clear
        apb(1, IRQ_CLR_IDX, 32'h7);
        apb(1, IRQ_EN_IDX, 32'h1);
        xfer(16'h0005);
        @(negedge pclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1, IRQ_EN_IDX, 32'h0);
        @(negedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1, IRQ_EN_IDX, 32'h1);
        apb(1, IRQ_CLR_IDX, 32'h1);
        @(negedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(0, IRQ_STAT_IDX, 0);
        chk("irq status", 32'h0, rd & 32'h1);
        // Snapshot modes; the manual bit only fires on a 0-to-1 write
        for (int i = 0; i < 9; i++) begin
            s0 = snaps;
            apb(1, CMD_IDX, {16'h0, mcmd[i]});
            strobe(npul[i]);
            repeat (8) @(posedge pclk);
            chk("snapshot count", 32'(ninc[i]), 32'(snaps - s0));
        end
        // Sticky overflow bits, clear by writing 0, set wins over clear
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            l = rnd[3:0];
            ev = (i == 0) ? 13'h1fff : rnd[16:4];
            c = rnd[29:17];
            apb(1, STAT_IDX + 12'(l), 32'h0);
            @(posedge pclk);
            ovf_ev[l] <= ev;
            @(posedge pclk);
            ovf_ev <= '0;
            apb(0, STAT_IDX + 12'(l), 0);
            chk("status set", stat_exp(13'h0, 13'h0, ev), rd);
            ev_on_wr[l] = {rnd[31], 11'h0, rnd[30]};
            apb(1, STAT_IDX + 12'(l), {19'h7ffff, c});
            apb(0, STAT_IDX + 12'(l), 0);
            chk("status clear", stat_exp(ev, c, ev_on_wr[l]), rd);
            ev_on_wr = '0;
        end
        // Snapshot and overflow sources latched since the last clear
        apb(0, IRQ_STAT_IDX, 0);
        chk("irq sources", 32'h6, rd);
        // Either line clock idle: events are not recorded
        for (int i = 1; i < 3; i++) begin
            apb(1, STAT_IDX + 12'h3, 32'h0);
            {rx_ok, tx_ok} <= 2'(i);
            repeat (4) @(posedge pclk);
            ovf_ev[3] <= 13'h1fff;
            @(posedge pclk);
            ovf_ev <= '0;
            repeat (4) @(posedge pclk);
            {rx_ok, tx_ok} <= 2'b11;
            repeat (4) @(posedge pclk);
            apb(0, STAT_IDX + 12'h3, 0);
            chk("status dead clock", 32'h0, rd);
        end
        print_verdict;
    end
endmodule
`default_nettype wire

// >>> verilog/sctlo_pkg.sv
`default_nettype none
package sctlo_pkg;
    // Register indices; byte address is four times the index
    localparam logic [11:0] CMD_IDX      = 12'h40f;
    localparam logic [11:0] STAT_IDX     = 12'h410;
    localparam logic [7:0]  STAT_IDX_HI  = 8'h41;
    localparam logic [11:0] CNT_HI_IDX   = 12'h430;
    localparam logic [11:0] CNT_MID_IDX  = 12'h431;
    localparam logic [11:0] CNT_LO_IDX   = 12'h432;
    localparam logic [11:0] CNT_SEL_IDX  = 12'h433;
    localparam logic [11:0] IRQ_STAT_IDX = 12'h440;
    localparam logic [11:0] IRQ_CLR_IDX  = 12'h441;
    localparam logic [11:0] IRQ_EN_IDX   = 12'h442;

    // Command register layout and reset
    localparam logic [15:0] CMD_RESET    = 16'h0080;
    localparam int          CMD_OP_LSB   = 0;
    localparam int          CMD_DIR_BIT  = 2;
    localparam int          CMD_IEN_BIT  = 3;
    localparam int          CMD_TGL_BIT  = 6;
    localparam int          CMD_DONE_BIT = 7;
    localparam int          CMD_MODE_LSB = 8;
    localparam int          CMD_MAN_BIT  = 10;
    localparam int          CMD_RSV_BIT  = 11;

    // Link overflow status: 16 links, 13 live bits each
    localparam int          NUM_LINKS    = 16;
    localparam int          STAT_W       = 13;
    localparam logic [12:0] STAT_RESET   = 13'h0000;

    // Block interrupt status bits
    localparam int          IRQ_W        = 3;
    localparam int          IRQ_DONE_BIT = 0;
    localparam int          IRQ_SNAP_BIT = 1;
    localparam int          IRQ_OVF_BIT  = 2;
    localparam logic [2:0]  IRQ_RESET    = 3'h0;

    // Strobe divider for the divided snapshot mode
    localparam int          STROBE_DIV      = 8000;
    localparam logic [13:0] STROBE_DIV_LAST = 14'(STROBE_DIV - 1);

    typedef enum logic [1:0] {
        LATCH_OFF   = 2'b00,
        LATCH_EVERY = 2'b01,
        LATCH_DIV   = 2'b10,
        LATCH_SW    = 2'b11
    } sctlo_latch_t;

    typedef enum logic [1:0] {
        OP_INIT  = 2'b00,
        OP_VALUE = 2'b01,
        OP_IEN   = 2'b10,
        OP_NONE  = 2'b11
    } sctlo_op_t;

    typedef enum logic [0:0] {
        XF_IDLE = 1'b0,
        XF_WAIT = 1'b1
    } sctlo_xfer_t;
endpackage
`default_nettype wire

// >>> verilog/sctlo_snap_if.sv
`timescale 1ns/10ps
`default_nettype none
// Snapshot control between register bank and strobe generator
interface sctlo_snap_if;
    import sctlo_pkg::*;
    sctlo_latch_t mode;
    logic         manual;
    logic         snap;
    modport ctrl (output mode, output manual, input snap);
    modport gen  (input mode, input manual, output snap);
endinterface
`default_nettype wire

// >>> verilog/sctlo_snapshot_gen.sv
`timescale 1ns/10ps
`default_nettype none
module sctlo_snapshot_gen
    import sctlo_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        counter_snapshot_strobe_pin,
    sctlo_snap_if.gen        sif
);
    logic [2:0]  strobe_sh;
    logic        strobe_rise;
    logic [13:0] div_cnt;
    logic        next_snap;

    // Two-stage synchroniser, third stage only for edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_sh <= 3'h0;
        end else begin
            strobe_sh <= {strobe_sh[1:0], counter_snapshot_strobe_pin};
        end
    end
    assign strobe_rise = strobe_sh[1] & ~strobe_sh[2];

    // Edge counter; held at zero outside the divided mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 14'h0;
        end else if (sif.mode != LATCH_DIV) begin
            div_cnt <= 14'h0;
        end else if (strobe_rise) begin
            div_cnt <= (div_cnt == STROBE_DIV_LAST) ? 14'h0 : div_cnt + 14'h1;
        end
    end

    // Mode picks the snapshot source
    always_comb begin
        case (sif.mode)
            LATCH_OFF:   next_snap = 1'b0;
            LATCH_EVERY: next_snap = strobe_rise;
            LATCH_DIV:   next_snap = strobe_rise && (div_cnt == STROBE_DIV_LAST);
            LATCH_SW:    next_snap = sif.manual;
            default:     next_snap = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sif.snap <= 1'b0;
        end else begin
            sif.snap <= next_snap;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_every_edge_snap: assert property (sif.mode == LATCH_EVERY && strobe_rise |=> sif.snap)
        else $error("strobe edge did not snapshot");
    a_div_full_count: assert property (sif.snap && $past(sif.mode) == LATCH_DIV
                                       |-> $past(div_cnt) == STROBE_DIV_LAST)
        else $error("divided snapshot before full count");
    a_off_no_snap: assert property ($past(sif.mode) == LATCH_OFF |-> !sif.snap)
        else $error("snapshot while latching off");
endmodule
`default_nettype wire

// >>> verilog/sctlo_top.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Mode 00 none, 01 every strobe edge, 10 every 8000 edges, 11 software.
// - In mode 11 a 0-to-1 write of the manual bit snapshots all counters.
// - Command bit 7 reads 1 when transfer done, 0 while pending; resets 0x0080.
// - Command bit 6 inverts on every host write access.
// - Op 00 clears counters, 01 moves value, 10 moves enable bit, 11 unused.
// - Direction 0 writes host data to counter, 1 reads counter to host.
// - Bit 3 is the enable value, applied only when op is 10.
// - Sixteen link status registers, working only while both line clocks run.
// - Bit 12 sets on receive cell FIFO overflow; writing 0 clears.
// - Bits 11..8 set on input cell counter overflows; writing 0 clears.
// - Bits 7..4 set on transmit line counter overflows.
// - Bits 3..1 set on receive line counter overflows.
// - Status bits 15..13 always read zero.
// - Bit 0 sets on bad control cell counter overflow.
// - Upper data register reads byte 3 of the selected counter.
module sctlo_top
    import sctlo_pkg::*;
(
    input  wire logic                               pclk,
    input  wire logic                               presetn,
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [15:0]                        paddr,
    input  wire logic [31:0]                        pwdata,
    output logic      [31:0]                        prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    input  wire logic                               counter_snapshot_strobe_pin,
    input  wire logic                               receive_line_clock_alive,
    input  wire logic                               transmit_line_clock_alive,
    input  wire logic [NUM_LINKS-1:0][STAT_W-1:0]   link_ovf_event,
    output logic                                    counter_snapshot,
    output logic                                    cnt_req,
    output sctlo_op_t                               cnt_op,
    output logic                                    cnt_dir,
    output logic                                    cnt_ien,
    output logic      [15:0]                        cnt_sel,
    output logic      [31:0]                        cnt_wdata,
    input  wire logic                               cnt_ack,
    input  wire logic [31:0]                        cnt_rdata,
    output logic                                    irq
);
    sctlo_snap_if sif ();

    logic [11:0]               idx;
    logic                      addr_ok;
    logic                      hit_cmd;
    logic                      hit_stat;
    logic [3:0]                link_sel;
    logic                      wr_en;
    logic                      rd_setup;
    logic [31:0]               next_rdata;
    logic                      next_err;
    logic                      err_q;
    sctlo_latch_t              cmd_mode;
    logic                      cmd_manual;
    logic                      cmd_rsv;
    logic [5:0]                cmd_low;
    logic                      cmd_tgl;
    logic [15:0]               cmd_rd;
    logic                      manual_pulse;
    sctlo_xfer_t               xf;
    logic                      start;
    logic                      xfer_done;
    sctlo_op_t                 req_op;
    logic                      req_dir;
    logic                      req_ien;
    logic [31:0]               cnt_data;
    logic [15:0]               sel_q;
    logic [1:0]                alive_s1;
    logic [1:0]                alive_s2;
    logic                      lines_ok;
    logic [NUM_LINKS-1:0][STAT_W-1:0] stat_q;
    logic [IRQ_W-1:0]          irq_stat;
    logic [IRQ_W-1:0]          irq_en;
    logic [IRQ_W-1:0]          irq_set;

    // Address decode; unaligned or out-of-window addresses are unmapped
    assign idx      = paddr[13:2];
    assign addr_ok  = (paddr[15:14] == 2'b00) && (paddr[1:0] == 2'b00);
    assign hit_cmd  = addr_ok && (idx == CMD_IDX);
    assign hit_stat = addr_ok && (idx[11:4] == STAT_IDX_HI);
    assign link_sel = idx[3:0];
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable;

    // Zero wait states: read data is captured in the setup cycle
    assign pready  = psel && penable;
    assign pslverr = psel && penable && err_q;

    // Command readback: done is live state, bits 15..12 read zero
    assign cmd_rd = {4'h0, cmd_rsv, cmd_manual, cmd_mode, (xf == XF_IDLE), cmd_tgl, cmd_low};

    // Read mux and unmapped detection
    always_comb begin
        next_rdata = 32'h0;
        next_err   = 1'b0;
        if (!addr_ok) begin
            next_err = 1'b1;
        end else if (hit_cmd) begin
            next_rdata = {16'h0, cmd_rd};
        end else if (hit_stat) begin
            next_rdata = {19'h0, stat_q[link_sel]};
        end else if (idx == CNT_HI_IDX) begin
            next_rdata = {24'h0, cnt_data[31:24]};
        end else if (idx == CNT_MID_IDX) begin
            next_rdata = {16'h0, cnt_data[23:8]};
        end else if (idx == CNT_LO_IDX) begin
            next_rdata = {24'h0, cnt_data[7:0]};
        end else if (idx == CNT_SEL_IDX) begin
            next_rdata = {16'h0, sel_q};
        end else if (idx == IRQ_STAT_IDX) begin
            next_rdata = {29'h0, irq_stat};
        end else if (idx == IRQ_EN_IDX) begin
            next_rdata = {29'h0, irq_en};
        end else if (idx != IRQ_CLR_IDX) begin
            next_err = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            err_q  <= 1'b0;
        end else if (rd_setup) begin
            prdata <= pwrite ? 32'h0 : next_rdata;
            err_q  <= next_err;
        end
    end

    // Command fields; reserved bit 11 is stored as written, bits 15..12 are not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_mode   <= sctlo_latch_t'(CMD_RESET[CMD_MODE_LSB+:2]);
            cmd_manual <= CMD_RESET[CMD_MAN_BIT];
            cmd_rsv    <= CMD_RESET[CMD_RSV_BIT];
            cmd_low    <= CMD_RESET[5:0];
        end else if (wr_en && hit_cmd) begin
            cmd_mode   <= sctlo_latch_t'(pwdata[CMD_MODE_LSB+:2]);
            cmd_manual <= pwdata[CMD_MAN_BIT];
            cmd_rsv    <= pwdata[CMD_RSV_BIT];
            cmd_low    <= pwdata[5:0];
        end
    end

    // Toggle bit flips on any write, whatever address or data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_tgl <= CMD_RESET[CMD_TGL_BIT];
        end else if (wr_en) begin
            cmd_tgl <= ~cmd_tgl;
        end
    end

    // Manual latch only on a 0-to-1 change with software mode written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            manual_pulse <= 1'b0;
        end else begin
            manual_pulse <= wr_en && hit_cmd && pwdata[CMD_MAN_BIT] && !cmd_manual
                            && (pwdata[CMD_MODE_LSB+:2] == LATCH_SW);
        end
    end

    assign sif.mode         = cmd_mode;
    assign sif.manual       = manual_pulse;
    assign counter_snapshot = sif.snap;

    sctlo_snapshot_gen u_snap (
        .pclk                        (pclk),
        .presetn                     (presetn),
        .counter_snapshot_strobe_pin (counter_snapshot_strobe_pin),
        .sif                         (sif)
    );

    // A new command is refused while one is pending
    assign start     = wr_en && hit_cmd && (pwdata[1:0] != OP_NONE) && (xf == XF_IDLE);
    assign xfer_done = (xf == XF_WAIT) && cnt_ack;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xf <= XF_IDLE;
        end else begin
            case (xf)
                XF_IDLE: if (start) begin
                    xf <= XF_WAIT;
                end
                XF_WAIT: if (cnt_ack) begin
                    xf <= XF_IDLE;
                end
                default: xf <= XF_IDLE;
            endcase
        end
    end

    // Request fields frozen for the whole transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_op  <= OP_INIT;
            req_dir <= 1'b0;
            req_ien <= 1'b0;
        end else if (start) begin
            req_op  <= sctlo_op_t'(pwdata[CMD_OP_LSB+:2]);
            req_dir <= pwdata[CMD_DIR_BIT];
            req_ien <= pwdata[CMD_IEN_BIT];
        end
    end

    assign cnt_req   = (xf == XF_WAIT);
    assign cnt_op    = req_op;
    assign cnt_dir   = req_dir;
    assign cnt_ien   = req_ien && (req_op == OP_IEN);
    assign cnt_sel   = sel_q;
    assign cnt_wdata = cnt_data;

    // Counter data: read-back from the bank wins over a host write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_data <= 32'h0;
        end else if (xfer_done && req_dir && (req_op != OP_INIT)) begin
            cnt_data <= cnt_rdata;
        end else if (wr_en && addr_ok && (idx == CNT_HI_IDX)) begin
            cnt_data[31:24] <= pwdata[7:0];
        end else if (wr_en && addr_ok && (idx == CNT_MID_IDX)) begin
            cnt_data[23:8] <= pwdata[15:0];
        end else if (wr_en && addr_ok && (idx == CNT_LO_IDX)) begin
            cnt_data[7:0] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= 16'h0;
        end else if (wr_en && addr_ok && (idx == CNT_SEL_IDX)) begin
            sel_q <= pwdata[15:0];
        end
    end

    // Line clock alive levels come from another domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alive_s1 <= 2'b00;
            alive_s2 <= 2'b00;
        end else begin
            alive_s1 <= {transmit_line_clock_alive, receive_line_clock_alive};
            alive_s2 <= alive_s1;
        end
    end
    assign lines_ok = &alive_s2;

    // Per-link sticky status; writing 0 clears, a same-cycle event wins
    for (genvar i = 0; i < NUM_LINKS; i++) begin : g_link
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stat_q[i] <= STAT_RESET;
            end else if (lines_ok) begin
                stat_q[i] <= (stat_q[i]
                              & ~((wr_en && hit_stat && link_sel == 4'(i)) ? ~pwdata[12:0] : 13'h0))
                             | link_ovf_event[i];
            end
        end
    end

    // Block interrupt: sticky events, write-1 clear, enable mask
    assign irq_set[IRQ_DONE_BIT] = xfer_done;
    assign irq_set[IRQ_SNAP_BIT] = sif.snap;
    assign irq_set[IRQ_OVF_BIT]  = lines_ok && (|link_ovf_event);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= IRQ_RESET;
            irq_en   <= IRQ_RESET;
        end else begin
            irq_stat <= (irq_stat & ~((wr_en && addr_ok && idx == IRQ_CLR_IDX)
                                      ? pwdata[IRQ_W-1:0] : IRQ_RESET)) | irq_set;
            if (wr_en && addr_ok && (idx == IRQ_EN_IDX)) begin
                irq_en <= pwdata[IRQ_W-1:0];
            end
        end
    end
    assign irq = |(irq_stat & irq_en);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_cmd_start;
        wr_en && hit_cmd && (pwdata[1:0] != OP_NONE) && (xf == XF_IDLE);
    endsequence
    sequence s_manual_write;
        wr_en && hit_cmd && pwdata[CMD_MAN_BIT] && !cmd_manual && (pwdata[9:8] == LATCH_SW);
    endsequence
    sequence s_stat_read;
        psel && !penable && !pwrite && hit_stat;
    endsequence

    a_manual_latch: assert property (s_manual_write |-> ##2 counter_snapshot)
        else $error("manual latch did not snapshot");
    a_done_pending: assert property (s_cmd_start
                                     |=> !cmd_rd[CMD_DONE_BIT] throughout (cnt_req [*1]))
        else $error("done bit not cleared by command");
    a_done_return: assert property (xfer_done |=> cmd_rd[CMD_DONE_BIT] && !cnt_req)
        else $error("done bit not set after ack");
    a_toggle_write: assert property (wr_en |=> cmd_tgl != $past(cmd_tgl))
        else $error("toggle bit did not flip");
    a_op_issue: assert property (s_cmd_start |=> cnt_req && cnt_op == $past(pwdata[1:0]))
        else $error("command op not issued");
    a_dir_follow: assert property (s_cmd_start |=> cnt_dir == $past(pwdata[CMD_DIR_BIT]))
        else $error("direction not taken");
    a_ien_gate: assert property (cnt_req && cnt_op != OP_IEN |-> !cnt_ien)
        else $error("enable value outside enable op");
    a_lines_gate: assert property (!lines_ok |=> stat_q == $past(stat_q))
        else $error("status moved without line clocks");
    a_event_sets: assert property (lines_ok && (|link_ovf_event)
                                   |=> (stat_q & $past(link_ovf_event)) == $past(link_ovf_event))
        else $error("overflow event lost");
    a_unused_zero: assert property (s_stat_read |=> prdata[31:13] == 19'h0)
        else $error("unused status bits not zero");
    a_upper_byte: assert property (psel && !penable && !pwrite && addr_ok
                                   && (idx == CNT_HI_IDX)
                                   |=> prdata == {24'h0, $past(cnt_data[31:24])})
        else $error("upper byte readback wrong");
endmodule
`default_nettype wire
